// ---- crc_card_model.sv ----
// Behavioural card and receive front end that drives the receive events
`timescale 1ns/100ps
module crc_card_model
(
  // Clock
  input  wire logic       hclk,
  // Receive events
  output logic            tx_done,
  output logic            sof_detect,
  output logic            subcarrier_detect,
  output logic            rx_byte_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_partial,
  output logic            rx_crc_enable,
  output logic            rx_error,
  output logic            rx_collision,
  output logic            rx_frame_end,
  output logic      [7:0] error_reg
);
  initial
  begin
    {tx_done, sof_detect, subcarrier_detect, rx_byte_valid, rx_partial} = '0;
    {rx_crc_enable, rx_error, rx_collision, rx_frame_end} = '0;
    rx_byte = 8'h00;
    error_reg = 8'h00;
  end

  // One-cycle strobes; byte line scrambled outside its strobe
  task automatic ev(input logic [4:0] m, input logic [7:0] d, input logic p);
    @(posedge hclk);
    {tx_done, rx_byte_valid, rx_error, rx_collision, rx_frame_end} <= m;
    rx_byte <= d;
    rx_partial <= p;
    @(posedge hclk);
    {tx_done, rx_byte_valid, rx_error, rx_collision, rx_frame_end} <= 5'h00;
    rx_byte <= ~d;
    rx_partial <= ~p;
  endtask

  task automatic lvl(input logic s, input logic c);
    @(posedge hclk);
    sof_detect <= s;
    subcarrier_detect <= c;
  endtask

  task automatic cfg(input logic c, input logic [7:0] e);
    @(posedge hclk);
    rx_crc_enable <= c;
    error_reg <= e;
  endtask
endmodule

// ---- crc_pkg.sv ----
// Register map, field positions and timing constants for the receive control block
package crc_pkg;

  // Register indexes (0x34..0x3A are not all multiples of four, so byte address is index << BYTE_ADDR_SHIFT)
  localparam logic [7:0] REG_FRAME_DETECT_IDX   = 8'h34;
  localparam logic [7:0] REG_CONTROL_IDX        = 8'h35;
  localparam logic [7:0] REG_DEAD_TIME_IDX      = 8'h36;
  localparam logic [7:0] REG_MIN_LEVELS_IDX     = 8'h37;
  localparam logic [7:0] REG_INPUT_CONFIG_IDX   = 8'h38;
  localparam logic [7:0] REG_ANALOG_IDX         = 8'h39;
  localparam logic [7:0] REG_ERROR_COPY_IDX     = 8'h3A;
  localparam int         BYTE_ADDR_SHIFT        = 2;

  // Frame-detect register fields
  localparam int FD_SOF_IRQ_EN   = 5;
  localparam int FD_SOF_SEEN     = 4;
  localparam int FD_SUBC_IRQ_EN  = 2;
  localparam int FD_SUBC_SEEN    = 1;
  localparam int FD_SUBC_LIVE    = 0;

  // Control register fields
  localparam int CTL_ALLOW_PART  = 7;
  localparam int CTL_MULTI       = 6;
  localparam int CTL_SUPPRESS    = 3;

  // Writable masks, reserved bits read zero
  localparam logic [7:0] MASK_FRAME_DETECT = 8'h24;
  localparam logic [7:0] MASK_CONTROL      = 8'hCF;
  localparam logic [7:0] MASK_DEAD_TIME    = 8'hFF;
  localparam logic [7:0] MASK_MIN_LEVELS   = 8'hFF;
  localparam logic [7:0] MASK_INPUT_CONFIG = 8'hF3;
  localparam logic [7:0] MASK_ANALOG       = 8'h0F;

  localparam logic [7:0] RESET_BYTE        = 8'h00;

  // Baud codes
  localparam logic [2:0] BAUD_106 = 3'h4;
  localparam logic [2:0] BAUD_212 = 3'h5;
  localparam logic [2:0] BAUD_424 = 3'h6;
  localparam logic [2:0] BAUD_847 = 3'h7;

  // Dead-time unit: 16 carrier periods at 13.56 MHz, in ns, against a 4 ns clock
  localparam int CARRIER_UNIT_NS = 1180;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int CARRIER_UNIT_CYC = CARRIER_UNIT_NS / CLK_PERIOD_NS;
  // Half bit period for 106 kBd = 4720 ns; faster rates shift right
  localparam int HALF_BIT_106_NS  = 4720;
  localparam int HALF_BIT_106_CYC = HALF_BIT_106_NS / CLK_PERIOD_NS;
  localparam int UNIT_CNT_W       = 11;

  localparam logic [1:0] EMD_BYTE_LIMIT = 2'd3;

endpackage

// ---- crc_receive_control.sv ----
// Receive-side control, status and FIFO write policy with an AHB-Lite register slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps

module crc_receive_control
  import crc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Receiver events
  input  wire logic        tx_done,
  input  wire logic        sof_detect,
  input  wire logic        subcarrier_detect,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_partial,
  input  wire logic        rx_crc_enable,
  input  wire logic        rx_error,
  input  wire logic        rx_collision,
  input  wire logic        rx_frame_end,
  input  wire logic [7:0]  error_reg,
  // FIFO side
  output logic             fifo_wr,
  output logic      [7:0]  fifo_wdata,
  output logic             fifo_flush,
  // Results to the receiver
  output logic             frame_start_interrupt,
  output logic             rx_complete_set,
  output logic             rx_running,
  output logic             rx_input_blocked,
  output logic      [2:0]  baud_select,
  output logic      [3:0]  decoder_min_level,
  output logic      [3:0]  phase_detector_min_level,
  output logic             converter_mode_select,
  output logic      [1:0]  input_source_select,
  output logic      [1:0]  collision_threshold,
  output logic             single_input_mode,
  output logic      [1:0]  highpass_select,
  output logic      [1:0]  gain_select
);

  typedef struct packed {
    logic        ph_valid;
    logic        ph_write;
    logic [7:0]  ph_idx;
    logic [7:0]  frame_detect;
    logic [7:0]  control;
    logic [7:0]  dead_time;
    logic [7:0]  min_levels;
    logic [7:0]  input_config;
    logic [7:0]  analog;
    logic [31:0] rdata;
    logic [UNIT_CNT_W-1:0] unit_cnt;
    logic [6:0]  dead_cnt;
    logic        running;
    logic [1:0]  byte_cnt;
    logic        frame_err;
    logic [2:0][7:0] held;
    logic [1:0]  hold_cnt;
    logic        passed;
    logic        wr;
    logic [7:0]  wdata;
    logic        flush;
    logic        complete;
    logic        append_err;
  } crc_state_s;

  crc_state_s st_ff;
  crc_state_s nxt_st;

  // Half bit period of the selected rate, in clock cycles
  function automatic logic [UNIT_CNT_W-1:0] half_bit_cycles(input logic [2:0] code);
    logic [UNIT_CNT_W-1:0] base;
    base = UNIT_CNT_W'(HALF_BIT_106_CYC);
    unique case (code)
      BAUD_212: half_bit_cycles = base >> 1;
      BAUD_424: half_bit_cycles = base >> 2;
      BAUD_847: half_bit_cycles = base >> 3;
      default:  half_bit_cycles = base;
    endcase
  endfunction

  logic        bus_wr;
  logic        bus_rd_take;
  logic [7:0]  wbyte;
  logic        in_ok;
  logic        frm_err_now;
  logic [UNIT_CNT_W-1:0] unit_len;

  always_comb
  begin
    nxt_st   = st_ff;
    bus_wr   = st_ff.ph_valid && st_ff.ph_write;
    wbyte    = hwdata[7:0];
    bus_rd_take = hsel && hready && htrans[1];
    nxt_st.wr = 1'b0;
    nxt_st.flush = 1'b0;
    nxt_st.complete = 1'b0;
    nxt_st.ph_valid = bus_rd_take;
    if (bus_rd_take)
    begin
      nxt_st.ph_write = hwrite;
      nxt_st.ph_idx   = haddr[9:2];
    end

    // Register writes, reserved bits held at zero
    if (bus_wr)
    begin
      unique case (st_ff.ph_idx)
        REG_FRAME_DETECT_IDX:
        begin
          nxt_st.frame_detect = (wbyte & MASK_FRAME_DETECT) |
                                (st_ff.frame_detect & ~MASK_FRAME_DETECT);
          // Writing zero clears a sticky flag
          if (!wbyte[FD_SOF_SEEN])
            nxt_st.frame_detect[FD_SOF_SEEN] = 1'b0;
          if (!wbyte[FD_SUBC_SEEN])
            nxt_st.frame_detect[FD_SUBC_SEEN] = 1'b0;
        end
        REG_CONTROL_IDX:      nxt_st.control      = wbyte & MASK_CONTROL;
        REG_DEAD_TIME_IDX:    nxt_st.dead_time    = wbyte & MASK_DEAD_TIME;
        REG_MIN_LEVELS_IDX:   nxt_st.min_levels   = wbyte & MASK_MIN_LEVELS;
        REG_INPUT_CONFIG_IDX: nxt_st.input_config = wbyte & MASK_INPUT_CONFIG;
        REG_ANALOG_IDX:       nxt_st.analog       = wbyte & MASK_ANALOG;
        default: ;
      endcase
    end

    // Sticky flags: detection wins over the clear
    if (sof_detect && in_ok)
      nxt_st.frame_detect[FD_SOF_SEEN] = 1'b1;
    if (subcarrier_detect && in_ok)
      nxt_st.frame_detect[FD_SUBC_SEEN] = 1'b1;
    nxt_st.frame_detect[FD_SUBC_LIVE] = subcarrier_detect && in_ok;

    // Past the disturbance window the queue drains one byte a cycle, in order
    if (st_ff.passed && st_ff.hold_cnt != '0)
    begin
      nxt_st.wr       = 1'b1;
      nxt_st.wdata    = st_ff.held[0];
      nxt_st.held     = {8'h00, st_ff.held[2:1]};
      nxt_st.hold_cnt = st_ff.hold_cnt - 2'h1;
    end

    // Dead time after transmit
    unit_len = st_ff.dead_time[7] ? half_bit_cycles(st_ff.control[2:0])
                                  : UNIT_CNT_W'(CARRIER_UNIT_CYC);
    if (tx_done)
    begin
      nxt_st.dead_cnt = st_ff.dead_time[6:0];
      nxt_st.unit_cnt = '0;
      nxt_st.running  = 1'b1;
      nxt_st.byte_cnt = '0;
      nxt_st.frame_err = 1'b0;
      nxt_st.hold_cnt = '0;
      nxt_st.passed   = 1'b0;
    end
    else if (st_ff.dead_cnt != '0)
    begin
      if (st_ff.unit_cnt >= unit_len - UNIT_CNT_W'(1))
      begin
        nxt_st.unit_cnt = '0;
        nxt_st.dead_cnt = st_ff.dead_cnt - 7'd1;
      end
      else
        nxt_st.unit_cnt = st_ff.unit_cnt + UNIT_CNT_W'(1);
    end

    // Collision counts as error only under suppression
    frm_err_now = rx_error || (st_ff.control[CTL_SUPPRESS] && rx_collision);

    if (in_ok && st_ff.running)
    begin
      if (frm_err_now)
        nxt_st.frame_err = 1'b1;
      if (rx_byte_valid && (!rx_partial || !rx_crc_enable || st_ff.control[CTL_ALLOW_PART]))
      begin
        if (st_ff.control[CTL_SUPPRESS])
        begin
          // Every byte queues; the first three may still turn out to be disturbance
          nxt_st.held[nxt_st.hold_cnt] = rx_byte;
          nxt_st.hold_cnt = nxt_st.hold_cnt + 2'h1;
          if (st_ff.byte_cnt < EMD_BYTE_LIMIT)
            nxt_st.byte_cnt = st_ff.byte_cnt + 2'h1;
          if (st_ff.byte_cnt == EMD_BYTE_LIMIT - 2'h1 && !frm_err_now)
            nxt_st.passed = 1'b1;
        end
        else
        begin
          nxt_st.wr = 1'b1;
          nxt_st.wdata = rx_byte;
        end
      end
      if (st_ff.control[CTL_SUPPRESS] && st_ff.byte_cnt < EMD_BYTE_LIMIT &&
          (frm_err_now || rx_frame_end))
      begin
        // Disturbance: drop and start over, no completion
        nxt_st.flush    = 1'b1;
        nxt_st.byte_cnt = '0;
        nxt_st.frame_err = 1'b0;
        nxt_st.hold_cnt = '0;
        nxt_st.wr       = 1'b0;
      end
      else if (rx_frame_end)
      begin
        nxt_st.complete   = 1'b1;
        nxt_st.append_err = st_ff.control[CTL_MULTI];
        nxt_st.byte_cnt   = '0;
        nxt_st.running    = st_ff.control[CTL_MULTI];
      end
    end
    if (st_ff.append_err && !nxt_st.wr)
    begin
      nxt_st.wr = 1'b1;
      nxt_st.wdata = error_reg;
      nxt_st.append_err = 1'b0;
    end

    // Window reopens once the frame has ended and drained; limitation: a frame
    // that starts before the drain ends skips its own disturbance window
    if (nxt_st.byte_cnt == '0 && nxt_st.hold_cnt == '0)
      nxt_st.passed = 1'b0;

    // Read data for the next data phase
    nxt_st.rdata = '0;
    if (bus_rd_take && !hwrite)
    begin
      unique case (haddr[9:2])
        REG_FRAME_DETECT_IDX:  nxt_st.rdata[7:0] = nxt_st.frame_detect;
        REG_CONTROL_IDX:       nxt_st.rdata[7:0] = nxt_st.control;
        REG_DEAD_TIME_IDX:     nxt_st.rdata[7:0] = nxt_st.dead_time;
        REG_MIN_LEVELS_IDX:    nxt_st.rdata[7:0] = nxt_st.min_levels;
        REG_INPUT_CONFIG_IDX:  nxt_st.rdata[7:0] = nxt_st.input_config;
        REG_ANALOG_IDX:        nxt_st.rdata[7:0] = nxt_st.analog;
        REG_ERROR_COPY_IDX:    nxt_st.rdata[7:0] = error_reg;
        default:               nxt_st.rdata = '0;
      endcase
    end
  end

  assign in_ok = (st_ff.dead_cnt == '0) && !tx_done;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata    = st_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign frame_start_interrupt =
    (st_ff.frame_detect[FD_SOF_IRQ_EN] && st_ff.frame_detect[FD_SOF_SEEN]) ||
    (st_ff.frame_detect[FD_SUBC_IRQ_EN] && st_ff.frame_detect[FD_SUBC_SEEN]);
  assign fifo_wr          = st_ff.wr;
  assign fifo_wdata       = st_ff.wdata;
  assign fifo_flush       = st_ff.flush;
  assign rx_complete_set  = st_ff.complete;
  assign rx_running       = st_ff.running;
  assign rx_input_blocked = st_ff.dead_cnt != '0;
  assign baud_select      = st_ff.control[2:0];
  assign decoder_min_level        = st_ff.min_levels[7:4];
  assign phase_detector_min_level = st_ff.min_levels[3:0];
  assign single_input_mode     = st_ff.input_config[7];
  assign converter_mode_select = st_ff.input_config[6];
  assign input_source_select   = st_ff.input_config[5:4];
  assign collision_threshold   = st_ff.input_config[1:0];
  assign highpass_select  = st_ff.analog[3:2];
  assign gain_select      = st_ff.analog[1:0];

  sticky_sof_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sof_detect && in_ok) |=> st_ff.frame_detect[FD_SOF_SEEN])
    else $error("sof flag not set");
  sticky_subc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (subcarrier_detect && in_ok) |=> st_ff.frame_detect[FD_SUBC_SEEN])
    else $error("subcarrier flag not set");
  live_subc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.frame_detect[FD_SUBC_LIVE] == $past(subcarrier_detect && in_ok))
    else $error("live bit wrong");
  sof_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.frame_detect[FD_SOF_IRQ_EN] && st_ff.frame_detect[FD_SOF_SEEN])
      |-> frame_start_interrupt)
    else $error("sof irq missing");
  dead_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_input_blocked |=> !st_ff.frame_detect[FD_SUBC_LIVE])
    else $error("input seen in dead time");
  emd_complete_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fifo_flush |-> !rx_complete_set)
    else $error("complete during disturbance");
  multi_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_complete_set && st_ff.control[CTL_MULTI]) |-> rx_running)
    else $error("receiver stopped in multi mode");
  reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.control & ~MASK_CONTROL) == '0 && st_ff.analog[7:4] == '0)
    else $error("reserved bits set");

  // Receive path, dead time and bus read checks
  sub_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.frame_detect[FD_SUBC_IRQ_EN] && st_ff.frame_detect[FD_SUBC_SEEN])
      |-> frame_start_interrupt)
    else $error("subcarrier irq missing");
  collision_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_ok && st_ff.running && st_ff.control[CTL_SUPPRESS] && rx_collision &&
     st_ff.byte_cnt < EMD_BYTE_LIMIT) |=> fifo_flush)
    else $error("collision not treated as disturbance");
  flush_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fifo_flush |-> (st_ff.hold_cnt == '0 && !st_ff.passed))
    else $error("held bytes survive a flush");
  err_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(st_ff.append_err) |-> (fifo_wr && fifo_wdata == $past(error_reg)))
    else $error("error copy byte missing");
  partial_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_ok && st_ff.running && rx_byte_valid && rx_partial && rx_crc_enable &&
     !st_ff.control[CTL_ALLOW_PART] && st_ff.hold_cnt == '0 && !st_ff.append_err)
      |=> !fifo_wr)
    else $error("partial byte written");
  dead_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_done |=> (st_ff.dead_cnt == $past(st_ff.dead_time[6:0])))
    else $error("dead time not loaded");
  unit_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_input_blocked |-> (st_ff.unit_cnt < unit_len))
    else $error("dead time unit overrun");
  complete_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_complete_set && !st_ff.control[CTL_MULTI]) |-> !rx_running)
    else $error("receiver kept running");
  read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == '0)
    else $error("upper read data not zero");

endmodule

// ---- crc_receive_control_bench.sv ----
// Self-checking bench for the receive control block
`timescale 1ns/100ps
module crc_receive_control_bench;
  import crc_pkg::*;
  localparam logic [4:0] TX = 5'h10, BY = 5'h08, ER = 5'h04, CO = 5'h02, EN = 5'h01;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, tx_done, sof_detect, subcarrier_detect, rx_byte_valid;
  logic        rx_partial, rx_crc_enable, rx_error, rx_collision, rx_frame_end;
  logic [7:0]  rx_byte, error_reg, fifo_wdata;
  logic        fifo_wr, fifo_flush, frame_start_interrupt, rx_complete_set, rx_running;
  logic        rx_input_blocked, converter_mode_select, single_input_mode;
  logic [2:0]  baud_select;
  logic [3:0]  decoder_min_level, phase_detector_min_level;
  logic [1:0]  input_source_select, collision_threshold, highpass_select, gain_select;
  int          fails = 0, n_compared = 0, n_flush = 0, n_done = 0;
  logic [7:0]  wq[$];

  always #2 hclk = ~hclk;

  crc_receive_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_done, .sof_detect,
    .subcarrier_detect, .rx_byte_valid, .rx_byte, .rx_partial, .rx_crc_enable, .rx_error,
    .rx_collision, .rx_frame_end, .error_reg, .fifo_wr, .fifo_wdata, .fifo_flush,
    .frame_start_interrupt, .rx_complete_set, .rx_running, .rx_input_blocked, .baud_select,
    .decoder_min_level, .phase_detector_min_level, .converter_mode_select,
    .input_source_select, .collision_threshold, .single_input_mode, .highpass_select,
    .gain_select);
  crc_card_model card (.hclk, .tx_done, .sof_detect, .subcarrier_detect, .rx_byte_valid,
    .rx_byte, .rx_partial, .rx_crc_enable, .rx_error, .rx_collision, .rx_frame_end,
    .error_reg);

  always @(posedge hclk)
  begin
    if (fifo_wr === 1'b1) wq.push_back(fifo_wdata);
    if (fifo_flush === 1'b1) n_flush++;
    if (rx_complete_set === 1'b1) n_done++;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 32'(i) << BYTE_ADDR_SHIFT;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, r);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, i, 8'h00, r);
    chk(r, e);
  endtask

  task automatic qchk(input int n, input logic [7:0] last);
    chk(8'(wq.size()), 8'(n));
    if (n > 0 && wq.size() > 0)
      chk(wq[$], last);
  endtask

  task automatic t_reset();
    for (int i = 8'h34; i <= 8'h3A; i++)
      rdc(8'(i), 8'h00);
    chk({7'h0, hresp}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [7:0] f;
    wr(REG_CONTROL_IDX, 8'hFF);
    wr(REG_DEAD_TIME_IDX, 8'hFF);
    wr(REG_MIN_LEVELS_IDX, 8'hFF);
    wr(REG_INPUT_CONFIG_IDX, 8'hFF);
    wr(REG_ANALOG_IDX, 8'h3F);
    wr(8'h3B, 8'hFF);
    rdc(REG_CONTROL_IDX, 8'hCF);
    rdc(REG_DEAD_TIME_IDX, 8'hFF);
    rdc(REG_MIN_LEVELS_IDX, 8'hFF);
    rdc(REG_INPUT_CONFIG_IDX, 8'hF3);
    rdc(REG_ANALOG_IDX, 8'h0F);
    rdc(8'h3B, 8'h00);
    chk({decoder_min_level, phase_detector_min_level}, 8'hFF);
    for (int k = 0; k < 4; k++)
    begin
      f = 8'(k);
      wr(REG_CONTROL_IDX, f + 8'h04);
      wr(REG_INPUT_CONFIG_IDX, {f[0], ~f[0], f[1:0], 2'b00, f[1:0]});
      wr(REG_ANALOG_IDX, {4'h0, f[1:0], ~f[1:0]});
      cyc(1);
      chk({5'h0, baud_select}, f + 8'h04);
      chk({single_input_mode, converter_mode_select, input_source_select, 2'b00,
           collision_threshold}, {f[0], ~f[0], f[1:0], 2'b00, f[1:0]});
      chk({4'h0, highpass_select, gain_select}, {4'h0, f[1:0], ~f[1:0]});
    end
    $display("test registers done");
  endtask

  task automatic t_flags();
    card.lvl(1'b1, 1'b0);
    cyc(3);
    card.lvl(1'b0, 1'b0);
    cyc(2);
    chk({7'h0, frame_start_interrupt}, 8'h00);
    rdc(REG_FRAME_DETECT_IDX, 8'h10);
    wr(REG_FRAME_DETECT_IDX, 8'h24);
    cyc(1);
    chk({7'h0, frame_start_interrupt}, 8'h00);
    card.lvl(1'b1, 1'b0);
    cyc(3);
    card.lvl(1'b0, 1'b0);
    cyc(2);
    chk({7'h0, frame_start_interrupt}, 8'h01);
    rdc(REG_FRAME_DETECT_IDX, 8'h34);
    wr(REG_FRAME_DETECT_IDX, 8'h04);
    rdc(REG_FRAME_DETECT_IDX, 8'h04);
    chk({7'h0, frame_start_interrupt}, 8'h00);
    card.lvl(1'b0, 1'b1);
    cyc(3);
    rdc(REG_FRAME_DETECT_IDX, 8'h07);
    chk({7'h0, frame_start_interrupt}, 8'h01);
    card.lvl(1'b0, 1'b0);
    cyc(2);
    rdc(REG_FRAME_DETECT_IDX, 8'h06);
    wr(REG_FRAME_DETECT_IDX, 8'h00);
    rdc(REG_FRAME_DETECT_IDX, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_dead();
    wq.delete();
    wr(REG_CONTROL_IDX, 8'h07);
    wr(REG_DEAD_TIME_IDX, 8'h02);
    card.ev(TX, 8'h00, 1'b0);
    cyc(2);
    chk({7'h0, rx_input_blocked}, 8'h01);
    card.ev(BY, 8'h3C, 1'b0);
    cyc(3);
    qchk(0, 8'h00);
    cyc(570);
    chk({7'h0, rx_input_blocked}, 8'h01);
    cyc(30);
    chk({7'h0, rx_input_blocked}, 8'h00);
    wr(REG_DEAD_TIME_IDX, 8'h81);
    card.ev(TX, 8'h00, 1'b0);
    cyc(135);
    chk({7'h0, rx_input_blocked}, 8'h01);
    cyc(20);
    chk({7'h0, rx_input_blocked}, 8'h00);
    $display("test dead time done");
  endtask

  task automatic t_frame();
    int d0;
    wq.delete();
    wr(REG_DEAD_TIME_IDX, 8'h00);
    wr(REG_CONTROL_IDX, 8'h04);
    card.cfg(1'b1, 8'h00);
    card.ev(TX, 8'h00, 1'b0);
    cyc(2);
    card.ev(BY, 8'hA5, 1'b0);
    card.ev(BY, 8'h0B, 1'b1);
    cyc(2);
    qchk(1, 8'hA5);
    wr(REG_CONTROL_IDX, 8'h84);
    card.ev(BY, 8'h0C, 1'b1);
    cyc(2);
    qchk(2, 8'h0C);
    d0 = n_done;
    card.ev(EN, 8'h00, 1'b0);
    cyc(3);
    chk(8'(n_done - d0), 8'h01);
    chk({7'h0, rx_running}, 8'h00);
    card.cfg(1'b0, 8'h5A);
    wq.delete();
    wr(REG_CONTROL_IDX, 8'h44);
    card.ev(TX, 8'h00, 1'b0);
    cyc(2);
    for (int k = 1; k <= 2; k++)
    begin
      card.ev(BY, 8'h11, 1'b0);
      card.ev(EN, 8'h00, 1'b0);
      cyc(4);
      qchk(2 * k, 8'h5A);
      chk({7'h0, rx_running}, 8'h01);
    end
    $display("test frames done");
  endtask

  task automatic t_emd();
    logic [4:0] term[3] = '{ER, CO, EN};
    int         nb[3] = '{2, 1, 2};
    int         f0, d0;
    wr(REG_CONTROL_IDX, 8'h0C);
    for (int c = 0; c < 4; c++)
    begin
      wq.delete();
      f0 = n_flush;
      d0 = n_done;
      card.ev(TX, 8'h00, 1'b0);
      cyc(2);
      for (int b = 0; b < (c < 3 ? nb[c] : 4); b++)
        card.ev(BY, 8'(8'h40 + b), 1'b0);
      card.ev(c < 3 ? term[c] : EN, 8'h00, 1'b0);
      cyc(4);
      chk(8'(n_flush - f0), c < 3 ? 8'h01 : 8'h00);
      chk(8'(n_done - d0), c < 3 ? 8'h00 : 8'h01);
      if (c < 3)
        qchk(0, 8'h00);
      else
      begin
        qchk(4, 8'h43);
        if (wq.size() == 4)
          chk(wq[1], 8'h41);
      end
    end
    $display("test suppression done");
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_flags();
    t_dead();
    t_frame();
    t_emd();
    end_sim();
  end
endmodule
